// ==== logic/lcb_pkg.sv ====
// constants for the per-unit configuration register bank
package lcb_pkg;
    localparam int LCB_UNITS = 9;
    localparam logic [7:0] LCB_UNIT_COUNT = 8'h09;
    localparam int LCB_POWER_UNITS = 6;

    // index offsets
    localparam logic [7:0] LCB_IDX_UNIT_SELECT = 8'h07;
    localparam logic [7:0] LCB_IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] LCB_IDX_BASE_HIGH = 8'h60;
    localparam logic [7:0] LCB_IDX_BASE_LOW = 8'h61;
    localparam logic [7:0] LCB_IDX_BASE2_HIGH = 8'h62;
    localparam logic [7:0] LCB_IDX_BASE2_LOW = 8'h63;
    localparam logic [7:0] LCB_IDX_IRQ_FIRST = 8'h70;
    localparam logic [7:0] LCB_IDX_IRQ_SECOND = 8'h72;
    localparam logic [7:0] LCB_IDX_DMA_FIRST = 8'h74;

    // field positions
    localparam int LCB_ACTIVATE_BIT = 0;
    localparam int LCB_IRQ_LEVEL_MSB = 3;

    // values after reset
    localparam logic [7:0] LCB_RST_UNIT_SELECT = 8'h00;
    localparam logic [7:0] LCB_RST_INDEX = 8'h00;
    localparam logic [7:0] LCB_RST_BASE = 8'h00;
    localparam logic [7:0] LCB_RST_IRQ = 8'h00;
    localparam logic [7:0] LCB_RST_DMA = 8'h04;
    localparam logic LCB_RST_ACTIVATE = 1'b0;
    localparam logic LCB_RST_IRQ_EDGE_HIGH = 1'b1;

    // per-unit features, bit n is unit n
    localparam logic [8:0] LCB_HAS_BASE2 = 9'h106;
    localparam logic [8:0] LCB_HAS_IRQ2 = 9'h080;
    localparam logic [8:0] LCB_HAS_DMA = 9'h009;
    localparam logic [8:0] LCB_FIXED_BASE = 9'h0c0;

    // permitted base ranges, indexed by unit
    localparam logic [15:0] LCB_BASE1_LO [LCB_UNITS] = '{
        16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0100,
        16'h0100, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] LCB_BASE1_HI [LCB_UNITS] = '{
        16'h0ff8, 16'h0ff8, 16'h0ff8, 16'h0ffc, 16'h0ff8,
        16'h0ff8, 16'hffff, 16'hffff, 16'h0fff};
    localparam logic [15:0] LCB_BASE1_ALIGN [LCB_UNITS] = '{
        16'h0007, 16'h0007, 16'h0007, 16'h0003, 16'h0007,
        16'h0007, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] LCB_BASE2_LO [LCB_UNITS] = '{
        16'h0000, 16'h0100, 16'h0100, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] LCB_BASE2_HI [LCB_UNITS] = '{
        16'hffff, 16'h0fff, 16'h0fff, 16'hffff, 16'hffff,
        16'hffff, 16'hffff, 16'hffff, 16'h0fff};
endpackage

// ==== logic/lcb_range_check.sv ====
// checks that a programmed base address lies in its permitted window
module lcb_range_check (
    input wire logic [15:0] base,
    input wire logic [15:0] low_limit,
    input wire logic [15:0] high_limit,
    input wire logic [15:0] align_mask,
    output logic in_range
);
    wire logic above_low = (base >= low_limit);
    wire logic below_high = (base <= high_limit);
    wire logic aligned = ((base & align_mask) == 16'h0000);

    assign in_range = above_low & below_high & aligned;
endmodule

// ==== logic/lcb_unit_bank.sv ====
// configuration registers of one logical unit
module lcb_unit_bank #(
    parameter bit HAS_BASE2 = 1'b0,
    parameter bit HAS_IRQ2 = 1'b0,
    parameter bit HAS_DMA = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [7:0] index,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic [15:0] base1,
    output logic [15:0] base2,
    output logic [7:0] irq_first,
    output logic [7:0] irq_second,
    output logic [7:0] dma_choice
);
    import lcb_pkg::*;

    logic [7:0] base_high;
    logic [7:0] base_low;
    logic [7:0] base2_high;
    logic [7:0] base2_low;
    logic [7:0] irq1;
    logic [7:0] irq2;
    logic [7:0] dma;

    wire logic hit_bh = (index == LCB_IDX_BASE_HIGH);
    wire logic hit_bl = (index == LCB_IDX_BASE_LOW);
    wire logic hit_b2h = HAS_BASE2 && (index == LCB_IDX_BASE2_HIGH);
    wire logic hit_b2l = HAS_BASE2 && (index == LCB_IDX_BASE2_LOW);
    wire logic hit_irq1 = (index == LCB_IDX_IRQ_FIRST);
    wire logic hit_irq2 = HAS_IRQ2 && (index == LCB_IDX_IRQ_SECOND);
    wire logic hit_dma = HAS_DMA && (index == LCB_IDX_DMA_FIRST);

    always_ff @(posedge clk) begin
        if (reset) begin
            base_high <= LCB_RST_BASE;
            base_low <= LCB_RST_BASE;
            base2_high <= LCB_RST_BASE;
            base2_low <= LCB_RST_BASE;
            irq1 <= LCB_RST_IRQ;
            irq2 <= LCB_RST_IRQ;
            dma <= LCB_RST_DMA;
        end else if (wr_en) begin
            if (hit_bh) begin
                base_high <= wdata;
            end
            if (hit_bl) begin
                base_low <= wdata;
            end
            if (hit_b2h) begin
                base2_high <= wdata;
            end
            if (hit_b2l) begin
                base2_low <= wdata;
            end
            if (hit_irq1) begin
                irq1 <= wdata;
            end
            if (hit_irq2) begin
                irq2 <= wdata;
            end
            if (hit_dma) begin
                dma <= wdata;
            end
        end
    end

    assign rdata = hit_bh ? base_high :
                   hit_bl ? base_low :
                   hit_b2h ? base2_high :
                   hit_b2l ? base2_low :
                   hit_irq1 ? irq1 :
                   hit_irq2 ? irq2 :
                   hit_dma ? dma : 8'h00;
    assign base1 = {base_high, base_low};
    assign base2 = HAS_BASE2 ? {base2_high, base2_low} : 16'h0000;
    assign irq_first = irq1;
    assign irq_second = HAS_IRQ2 ? irq2 : 8'h00;
    assign dma_choice = HAS_DMA ? dma : 8'h00;
endmodule

// ==== logic/lcb_config_bank.sv ====
// banked per-unit configuration registers behind the index and data ports
module lcb_config_bank (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CFG_MODE,
    input wire logic INDEX_WR,
    input wire logic DATA_WR,
    input wire logic DATA_RD,
    input wire logic [7:0] WDATA,
    input wire logic PWR_WR,
    input wire logic [lcb_pkg::LCB_POWER_UNITS-1:0] PWR_DATA,
    output logic [7:0] RDATA,
    output logic RDATA_VALID,
    output logic [7:0] UNIT_SELECT,
    output logic [lcb_pkg::LCB_UNITS-1:0] UNIT_ON,
    output logic [lcb_pkg::LCB_UNITS-1:0] UNIT_DECODE_OK,
    output logic [lcb_pkg::LCB_UNITS-1:0] UNIT_IRQ_ON,
    output logic IRQ_EDGE_HIGH
);
    import lcb_pkg::*;

    logic [7:0] index;
    logic [7:0] unit_sel;
    logic [LCB_UNITS-1:0] unit_enable;

    logic [7:0] bank_rdata [LCB_UNITS];
    logic [15:0] bank_base1 [LCB_UNITS];
    logic [15:0] bank_base2 [LCB_UNITS];
    logic [7:0] bank_irq1 [LCB_UNITS];
    logic [7:0] bank_irq2 [LCB_UNITS];
    logic [7:0] bank_dma [LCB_UNITS];

    logic [LCB_UNITS-1:0] next_enable;
    logic [LCB_UNITS-1:0] next_decode_ok;
    logic [LCB_UNITS-1:0] next_irq_on;
    logic [LCB_UNITS-1:0] base1_ok;
    logic [LCB_UNITS-1:0] base2_ok;

    wire logic index_wr_ok = INDEX_WR & CFG_MODE;
    wire logic data_wr_ok = DATA_WR & CFG_MODE;
    wire logic data_rd_ok = DATA_RD & CFG_MODE;

    wire logic sel_valid = (unit_sel < LCB_UNIT_COUNT);
    wire logic [3:0] sel_num = unit_sel[3:0];
    wire logic hit_select = (index == LCB_IDX_UNIT_SELECT);
    wire logic hit_activate = (index == LCB_IDX_ACTIVATE);
    // only base, interrupt and dma ranges reach a bank
    wire logic in_bank_range = (index >= LCB_IDX_BASE_HIGH) && (index <= LCB_IDX_DMA_FIRST);
    wire logic activate_wr = data_wr_ok & hit_activate & sel_valid;
    wire logic [7:0] activate_read = {7'h00, unit_enable[sel_num]};

    // reserved, vendor and unmapped read zero
    // vendor range and last address read zero
    wire logic [7:0] read_value = hit_select ? unit_sel :
                                  (hit_activate & sel_valid) ? activate_read :
                                  (in_bank_range & sel_valid) ? bank_rdata[sel_num] :
                                  8'h00;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            index <= LCB_RST_INDEX;
        end else if (index_wr_ok) begin
            index <= WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            unit_sel <= LCB_RST_UNIT_SELECT;
        end else if (data_wr_ok & hit_select) begin
            unit_sel <= WDATA;
        end
    end

    genvar u;
    generate
        for (u = 0; u < LCB_UNITS; u++) begin : g_unit
            lcb_unit_bank #(
                .HAS_BASE2(LCB_HAS_BASE2[u]),
                .HAS_IRQ2(LCB_HAS_IRQ2[u]),
                .HAS_DMA(LCB_HAS_DMA[u])
            ) u_bank (
                .clk(CLK),
                .reset(RESET),
                .wr_en(data_wr_ok & sel_valid & (sel_num == 4'(u)) & in_bank_range),
                .index(index),
                .wdata(WDATA),
                .rdata(bank_rdata[u]),
                .base1(bank_base1[u]),
                .base2(bank_base2[u]),
                .irq_first(bank_irq1[u]),
                .irq_second(bank_irq2[u]),
                .dma_choice(bank_dma[u])
            );

            lcb_range_check u_range1 (
                .base(bank_base1[u]),
                .low_limit(LCB_BASE1_LO[u]),
                .high_limit(LCB_BASE1_HI[u]),
                .align_mask(LCB_BASE1_ALIGN[u]),
                .in_range(base1_ok[u])
            );

            lcb_range_check u_range2 (
                .base(bank_base2[u]),
                .low_limit(LCB_BASE2_LO[u]),
                .high_limit(LCB_BASE2_HI[u]),
                .align_mask(16'h0000),
                .in_range(base2_ok[u])
            );

            // power write drives the same bit for units below LCB_POWER_UNITS only
            if (u < LCB_POWER_UNITS) begin : g_pwr
                // activate write for selected unit wins
                assign next_enable[u] =
                    (activate_wr && sel_num == 4'(u)) ? WDATA[LCB_ACTIVATE_BIT] :
                    PWR_WR ? PWR_DATA[u] : unit_enable[u];
            end else begin : g_nopwr
                assign next_enable[u] =
                    (activate_wr && sel_num == 4'(u)) ? WDATA[LCB_ACTIVATE_BIT] :
                    unit_enable[u];
            end

            assign next_decode_ok[u] = next_enable[u] &
                (LCB_FIXED_BASE[u] | (base1_ok[u] & (~LCB_HAS_BASE2[u] | base2_ok[u])));
            assign next_irq_on[u] = next_enable[u] &
                ((bank_irq1[u][LCB_IRQ_LEVEL_MSB:0] != 4'h0) |
                 (bank_irq2[u][LCB_IRQ_LEVEL_MSB:0] != 4'h0));
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (RESET) begin
            unit_enable <= '0;
            UNIT_ON <= '0;
            UNIT_DECODE_OK <= '0;
            UNIT_IRQ_ON <= '0;
        end else begin
            unit_enable <= next_enable;
            UNIT_ON <= next_enable;
            UNIT_DECODE_OK <= next_decode_ok;
            UNIT_IRQ_ON <= next_irq_on;
        end
    end

    // read answers only in configuration state
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= 8'h00;
            RDATA_VALID <= 1'b0;
        end else begin
            RDATA_VALID <= data_rd_ok;
            if (data_rd_ok) begin
                RDATA <= read_value;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ_EDGE_HIGH <= LCB_RST_IRQ_EDGE_HIGH;
            UNIT_SELECT <= LCB_RST_UNIT_SELECT;
        end else begin
            IRQ_EDGE_HIGH <= LCB_RST_IRQ_EDGE_HIGH;
            UNIT_SELECT <= (data_wr_ok & hit_select) ? WDATA : unit_sel;
        end
    end
endmodule

// ==== test/lcb_config_bank_assertions.sv ====
// concurrent checks on the configuration bank ports
module lcb_config_bank_assertions (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CFG_MODE,
    input wire logic INDEX_WR,
    input wire logic DATA_WR,
    input wire logic DATA_RD,
    input wire logic [7:0] WDATA,
    input wire logic PWR_WR,
    input wire logic [lcb_pkg::LCB_POWER_UNITS-1:0] PWR_DATA,
    input wire logic [7:0] RDATA,
    input wire logic RDATA_VALID,
    input wire logic [7:0] UNIT_SELECT,
    input wire logic [lcb_pkg::LCB_UNITS-1:0] UNIT_ON,
    input wire logic [lcb_pkg::LCB_UNITS-1:0] UNIT_DECODE_OK,
    input wire logic [lcb_pkg::LCB_UNITS-1:0] UNIT_IRQ_ON,
    input wire logic IRQ_EDGE_HIGH
);
    timeunit 1ns;
    timeprecision 1ps;
    import lcb_pkg::*;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    a_read_answers: assert property (CFG_MODE && DATA_RD |=> RDATA_VALID)
        else $error("accepted read gave no valid pulse");
    a_read_refused: assert property (!(CFG_MODE && DATA_RD) |=> !RDATA_VALID)
        else $error("valid pulse without accepted read");
    a_rdata_holds: assert property (!RDATA_VALID |-> $stable(RDATA) || $past(RESET))
        else $error("read data moved without a read");
    a_edge_high: assert property (IRQ_EDGE_HIGH)
        else $error("interrupt signalling not edge high");
    a_decode_gated: assert property ((UNIT_DECODE_OK & ~UNIT_ON) == '0)
        else $error("decode enabled for a unit that is off");
    a_irq_gated: assert property ((UNIT_IRQ_ON & ~UNIT_ON) == '0)
        else $error("interrupt enabled for a unit that is off");
    a_select_cause: assert property ($changed(UNIT_SELECT) |-> $past(RESET) ||
        ($past(CFG_MODE && DATA_WR) && UNIT_SELECT == $past(WDATA)))
        else $error("unit select moved without a data write");
    a_power_link: assert property ((PWR_WR && !DATA_WR) ##1 (!PWR_WR && !DATA_WR)
        |=> UNIT_ON[5:0] == $past(PWR_DATA, 2))
        else $error("power write not reflected in unit enables");
    a_reset_values: assert property ($past(RESET) |-> RDATA == 8'h00 && !RDATA_VALID
        && UNIT_SELECT == 8'h00 && UNIT_ON == '0)
        else $error("outputs not at reset values");
    cover property (RDATA_VALID);
    cover property (PWR_WR);
    cover property (UNIT_DECODE_OK != '0);
endmodule

// ==== test/lcb_host_model.sv ====
// host side model issuing index and data port cycles
module lcb_host_model (
    input wire logic CLK,
    input wire logic [7:0] RDATA,
    input wire logic RDATA_VALID,
    output logic INDEX_WR,
    output logic DATA_WR,
    output logic DATA_RD,
    output logic [7:0] WDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        INDEX_WR = 1'b0;
        DATA_WR = 1'b0;
        DATA_RD = 1'b0;
        WDATA = 8'h00;
    end
    task automatic put_index(input logic [7:0] idx);
        @(posedge CLK);
        #1;
        INDEX_WR = 1'b1;
        WDATA = idx;
        @(posedge CLK);
        #1;
        INDEX_WR = 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] val);
        put_index(idx);
        DATA_WR = 1'b1;
        WDATA = val;
        @(posedge CLK);
        #1;
        DATA_WR = 1'b0;
        WDATA = ~val;
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic v);
        put_index(idx);
        WDATA = ~idx;
        DATA_RD = 1'b1;
        @(posedge CLK);
        #1;
        DATA_RD = 1'b0;
        v = RDATA_VALID;
        d = RDATA;
    endtask
endmodule

// ==== test/lcb_config_bank_tb.sv ====
// self-checking bench for the configuration bank
module lcb_config_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lcb_pkg::*;
    typedef struct packed {logic [7:0] u; logic [7:0] i; logic [7:0] w; logic [7:0] e;} lcb_row_t;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic CFG_MODE = 1'b1;
    logic PWR_WR = 1'b0;
    logic [LCB_POWER_UNITS-1:0] PWR_DATA = '0;
    logic INDEX_WR, DATA_WR, DATA_RD, RDATA_VALID, IRQ_EDGE_HIGH, v;
    logic [7:0] WDATA, RDATA, UNIT_SELECT, d;
    logic [LCB_UNITS-1:0] UNIT_ON, UNIT_DECODE_OK, UNIT_IRQ_ON;
    int errors = 0;
    int n_checks = 0;
    lcb_row_t r;
    // unit, index, write value, expected read
    lcb_row_t rows [19] = '{32'h0030ff01, 32'h03601212, 32'h03613434, 32'h01620303,
        32'h08634545, 32'h00625500, 32'h05700a0a, 32'h07720505, 32'h04720500,
        32'h03740202, 32'h04740200, 32'h00750100, 32'h0031aa00, 32'h0040aa00,
        32'h0071aa00, 32'h00e0aa00, 32'h00ffaa00, 32'h09601100, 32'h026f1100};
    always #2 CLK = ~CLK;
    lcb_host_model u_host (.CLK(CLK), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID),
        .INDEX_WR(INDEX_WR), .DATA_WR(DATA_WR), .DATA_RD(DATA_RD), .WDATA(WDATA));
    lcb_config_bank u_dut (.CLK(CLK), .RESET(RESET), .CFG_MODE(CFG_MODE),
        .INDEX_WR(INDEX_WR), .DATA_WR(DATA_WR), .DATA_RD(DATA_RD), .WDATA(WDATA),
        .PWR_WR(PWR_WR), .PWR_DATA(PWR_DATA), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID),
        .UNIT_SELECT(UNIT_SELECT), .UNIT_ON(UNIT_ON), .UNIT_DECODE_OK(UNIT_DECODE_OK),
        .UNIT_IRQ_ON(UNIT_IRQ_ON), .IRQ_EDGE_HIGH(IRQ_EDGE_HIGH));
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        u_host.rd(idx, d, v);
        chk({8'h00, v}, 9'h001);
        chk({1'b0, d}, {1'b0, exp});
    endtask
    task automatic settle;
        repeat (2) @(posedge CLK);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        #1;
        RESET = 1'b0;
        chk(UNIT_ON, 9'h000);
        chk({8'h00, IRQ_EDGE_HIGH}, 9'h001);
        rdchk(8'h74, 8'h04);
        foreach (rows[k]) begin
            r = rows[k];
            u_host.wr(8'h07, r.u);
            u_host.wr(r.i, r.w);
            rdchk(r.i, r.e);
        end
        CFG_MODE = 1'b0;
        u_host.wr(8'h60, 8'h99);
        u_host.rd(8'h60, d, v);
        chk({8'h00, v}, 9'h000);
        CFG_MODE = 1'b1;
        rdchk(8'h60, 8'h00);
        u_host.wr(8'h30, 8'h01);
        settle;
        chk(UNIT_ON, 9'h005);
        PWR_WR = 1'b1;
        PWR_DATA = 6'h08;
        @(posedge CLK);
        #1;
        PWR_WR = 1'b0;
        settle;
        chk(UNIT_ON, 9'h008);
        u_host.wr(8'h07, 8'h03);
        rdchk(8'h30, 8'h01);
        chk(UNIT_DECODE_OK, 9'h000);
        u_host.wr(8'h60, 8'h03);
        u_host.wr(8'h61, 8'h78);
        u_host.wr(8'h70, 8'h07);
        settle;
        chk(UNIT_DECODE_OK, 9'h008);
        chk(UNIT_IRQ_ON, 9'h008);
        chk({1'b0, UNIT_SELECT}, 9'h003);
        RESET = 1'b1;
        settle;
        RESET = 1'b0;
        chk(UNIT_ON, 9'h000);
        u_host.wr(8'h07, 8'h03);
        rdchk(8'h60, 8'h00);
        final_report;
    end
    initial begin
        #20000;
        errors++;
        final_report;
    end
endmodule
bind lcb_config_bank lcb_config_bank_assertions u_chk (.CLK(CLK), .RESET(RESET),
    .CFG_MODE(CFG_MODE), .INDEX_WR(INDEX_WR), .DATA_WR(DATA_WR), .DATA_RD(DATA_RD),
    .WDATA(WDATA), .PWR_WR(PWR_WR), .PWR_DATA(PWR_DATA), .RDATA(RDATA),
    .RDATA_VALID(RDATA_VALID), .UNIT_SELECT(UNIT_SELECT), .UNIT_ON(UNIT_ON),
    .UNIT_DECODE_OK(UNIT_DECODE_OK), .UNIT_IRQ_ON(UNIT_IRQ_ON),
    .IRQ_EDGE_HIGH(IRQ_EDGE_HIGH));
